// File: rcs_host_model.sv
// Purpose: AHB-Lite host master standing in for the microprocessor
// Assumes: single whole-word transfers, OKAY response only
// Notes:   released write data shows the inverse of the last word
module rcs_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic [31:0]      o_haddr,
  output logic [1:0]       o_htrans,
  output logic             o_hwrite,
  output logic [2:0]       o_hsize,
  output logic [31:0]      o_hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import rcs_pkg::*;

  initial begin
    o_hsel   = 1'h0;
    o_haddr  = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'h0;
    o_hsize  = 3'h0;
    o_hwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_clk);
    o_hsel   <= 1'h1;
    o_htrans <= 2'h2;
    o_haddr  <= {24'h0, a};
    o_hwrite <= w;
    o_hsize  <= 3'h2;
    do @(posedge i_clk); while (i_hready !== 1'h1);
    o_hsel   <= 1'h0;
    o_htrans <= 2'h0;
    o_hsize  <= 3'h0;
    o_hwdata <= d;
    do @(posedge i_clk); while (i_hready !== 1'h1);
    q = i_hrdata;
    o_hwdata <= ~d;
  endtask

  task automatic write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
  endtask

  // bytes go in one at a time, ahead of the transmitter's need
  task automatic push(input logic [7:0] b);
    write(ADDR_FIFO_DATA, {24'h0, b});
  endtask

  // a truncated last byte never travels with a check code
  task automatic setup(input logic [3:0] red, input logic [2:0] last);
    write(ADDR_REDUNDANCY, {28'h0, red[3], red[2] & (last == 3'h0), red[1:0]});
    write(ADDR_FRAMING, {29'h0, last});
  endtask

  task automatic wait_idle(output logic ok);
    logic [31:0] q;
    ok = 1'h0;
    for (int i = 0; i < 50 && !ok; i++) begin
      xfer(1'h0, ADDR_STATUS, 32'h0, q);
      ok = (q[STAT_PWR_BUSY] === 1'h0);
    end
  endtask
endmodule

// File: rcs_pkg.sv
// Purpose: constants and types of the reader command sequencer
// Assumes: 25 MHz device clock, 32-bit AHB-Lite register window
// Notes:   every offset is a byte address of one aligned word
//
// Notes on behaviour
// - power-up sequence starts only from resets
// - power-up resets, then loads stored settings
// - power-up end enters idle automatically
// - during power-up only page 0 readable
// - idle code does nothing, waits
// - self-finished command sets idle flag
// - host idle aborts, no idle flag
// - abort leaves FIFO contents untouched
// - transmit code sends FIFO bytes, host-started
// - preloaded FIFO stream is sent whole
// - transmit on empty FIFO arms, waits
// - bytes written during transmit are appended
// - empty FIFO at request ends transmit
// - frame complete sets transmit done flag
// - replacing transmit code stops next cycle
// - frame is start, data, end; phase shown
// - check code appended when enabled
// - parity only when enabled, odd or even
// - nonzero final count truncates last byte
// - final count clears after transmission
// - FIFO empty checked at last bit only
package rcs_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_COMMAND    = 8'h04;
  localparam logic [7:0] ADDR_FIFO_DATA  = 8'h08;
  localparam logic [7:0] ADDR_FIFO_LEVEL = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS      = 8'h10;
  localparam logic [7:0] ADDR_REDUNDANCY = 8'h14;
  localparam logic [7:0] ADDR_FRAMING    = 8'h18;

  // ---------------------------------------------------------------
  // command codes and field positions
  // ---------------------------------------------------------------
  localparam logic [5:0] CMD_IDLE     = 6'h00;
  localparam logic [5:0] CMD_TRANSMIT = 6'h1a;
  localparam logic [5:0] CMD_POWER_UP = 6'h3f;

  localparam int STAT_FIFO_EMPTY = 3;
  localparam int STAT_FIFO_FULL  = 4;
  localparam int STAT_PWR_BUSY   = 5;
  localparam int FLAG_IDLE       = 0;
  localparam int FLAG_TX         = 1;
  localparam int RED_PARITY_EN   = 0;
  localparam int RED_ODD_SEL     = 1;
  localparam int RED_CHECK_EN    = 2;
  localparam int RED_CHECK8      = 3;

  localparam logic [2:0] PHASE_IDLE  = 3'h0;
  localparam logic [2:0] PHASE_ARMED = 3'h1;
  localparam logic [2:0] PHASE_SOF   = 3'h2;
  localparam logic [2:0] PHASE_DATA  = 3'h3;
  localparam logic [2:0] PHASE_EOF   = 3'h4;

  // ---------------------------------------------------------------
  // reset values, stored settings, check code polynomials
  // ---------------------------------------------------------------
  localparam logic [3:0]  RED_RESET        = 4'h0;
  localparam logic [3:0]  RED_STORED       = 4'h3;
  localparam logic [2:0]  FRAMING_STORED   = 3'h0;
  localparam logic [15:0] CHECK16_POLY     = 16'h8408;
  localparam logic [15:0] CHECK16_PRESET   = 16'hffff;
  localparam logic [7:0]  CHECK8_POLY      = 8'hb8;
  localparam logic [7:0]  CHECK8_PRESET    = 8'hff;
  localparam logic [3:0]  LOAD_CYCLES      = 4'h8;
  localparam int          FIFO_DEPTH       = 64;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS     = 40;
  localparam int BIT_NS     = 9440;
  localparam int BIT_CYCLES = BIT_NS / CLK_NS;

  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_IDLE,
    ST_TX_ARMED,
    ST_TX_SOF,
    ST_TX_DATA,
    ST_TX_CHECK,
    ST_TX_EOF,
    ST_TX_END
  } rcs_state_t;

endpackage

// File: rcs_sequencer.sv
// Purpose: command sequencer with power-up, idle and transmit commands
// Assumes: one AHB-Lite master, zero-wait slave, pin input asynchronous
// Notes:   o_tx_bit holds one bit per bit period while o_tx_active is high
module rcs_sequencer #(
  parameter int BIT_DIV = rcs_pkg::BIT_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_reset_powerdown_pin,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_tx_bit,
  output logic             o_tx_active
);
  import rcs_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rcs_state_t  state;
  logic [7:0]  fifo_mem [FIFO_DEPTH];
  logic [5:0]  wptr, rptr;
  logic [6:0]  fifo_count;
  logic        pin_q1, pin_q2, pin_q3;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic [3:0]  load_cnt;
  logic [3:0]  redundancy_config_reg;
  logic [2:0]  final_byte_bit_count;
  logic [1:0]  flags;
  logic [15:0] div_cnt;
  logic [7:0]  shreg, check_hi;
  logic        check_left;
  logic [3:0]  bit_idx;
  logic [15:0] crc, next_crc;
  logic        pu_restart, pu_done, tick, wr_cmd, abort, in_tx, tx_finish;
  logic        fifo_empty, fifo_full, push, pop, start_load, cont_pop;
  logic        byte_last, part_last, par_bit, slot_bit;
  logic [2:0]  link_phase_field;
  logic [5:0]  cur_cmd;

  wire parity_gen_en      = redundancy_config_reg[RED_PARITY_EN];
  wire odd_parity_sel     = redundancy_config_reg[RED_ODD_SEL];
  wire tx_check_append_en = redundancy_config_reg[RED_CHECK_EN];
  wire check8_sel         = redundancy_config_reg[RED_CHECK8];

  // ---------------------------------------------------------------
  // reset pin synchroniser; a falling edge reruns power-up
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_q1 <= 1'b1;
      pin_q2 <= 1'b1;
      pin_q3 <= 1'b1;
    end else begin
      pin_q1 <= i_reset_powerdown_pin;
      pin_q2 <= pin_q1;
      pin_q3 <= pin_q2;
    end
  end
  assign pu_restart = pin_q3 & ~pin_q2;

  // ---------------------------------------------------------------
  // bus slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [7:0] a, input logic busy);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      ADDR_STATUS:     w = {26'h0, busy, fifo_full, fifo_empty, link_phase_field};
      ADDR_COMMAND:    w = {26'h0, cur_cmd};
      ADDR_FIFO_LEVEL: w = {25'h0, fifo_count};
      ADDR_FLAGS:      w = {30'h0, flags};
      ADDR_REDUNDANCY: w = {28'h0, redundancy_config_reg};
      ADDR_FRAMING:    w = {29'h0, final_byte_bit_count};
      default:         w = 32'h0000_0000;
    endcase
    // other registers stay hidden while the sequence runs
    if (busy && a != ADDR_STATUS) begin
      w = 32'h0000_0000;
    end
    return w;
  endfunction

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dp_wr    <= 1'b0;
      dp_addr  <= 8'h00;
      o_hrdata <= 32'h0000_0000;
    end else begin
      dp_wr   <= i_hsel & i_htrans[1] & i_hready & i_hwrite;
      dp_addr <= i_haddr[7:0];
      if (i_hsel && i_htrans[1] && i_hready && !i_hwrite) begin
        o_hrdata <= read_word(i_haddr[7:0], state == ST_POWER_UP);
      end
    end
  end

  // writes land in the data phase; all of them are dropped in power-up
  assign wr_cmd = dp_wr && dp_addr == ADDR_COMMAND && state != ST_POWER_UP;
  assign in_tx  = state != ST_POWER_UP && state != ST_IDLE;
  // the host cannot launch power-up, so its code is not a replacement
  assign abort  = wr_cmd && in_tx && i_hwdata[5:0] != CMD_TRANSMIT
                  && i_hwdata[5:0] != CMD_POWER_UP;

  always_comb begin
    case (state)
      ST_POWER_UP: cur_cmd = CMD_POWER_UP;
      ST_IDLE:     cur_cmd = CMD_IDLE;
      default:     cur_cmd = CMD_TRANSMIT;
    endcase
  end

  always_comb begin
    case (state)
      ST_TX_ARMED: link_phase_field = PHASE_ARMED;
      ST_TX_SOF:   link_phase_field = PHASE_SOF;
      ST_TX_DATA:  link_phase_field = PHASE_DATA;
      ST_TX_CHECK: link_phase_field = PHASE_DATA;
      ST_TX_EOF:   link_phase_field = PHASE_EOF;
      ST_TX_END:   link_phase_field = PHASE_EOF;
      default:     link_phase_field = PHASE_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // power-up: reset phase, then stored settings are loaded
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      load_cnt <= 4'h0;
    end else if (pu_restart || state != ST_POWER_UP) begin
      load_cnt <= 4'h0;
    end else begin
      load_cnt <= load_cnt + 4'h1;
    end
  end
  assign pu_done = state == ST_POWER_UP && !pu_restart && load_cnt == LOAD_CYCLES - 4'h1;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      redundancy_config_reg <= RED_RESET;
    end else if (pu_restart) begin
      redundancy_config_reg <= RED_RESET;
    end else if (pu_done) begin
      redundancy_config_reg <= RED_STORED;
    end else if (dp_wr && dp_addr == ADDR_REDUNDANCY && state != ST_POWER_UP) begin
      redundancy_config_reg <= i_hwdata[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      final_byte_bit_count <= 3'h0;
    end else if (pu_restart) begin
      final_byte_bit_count <= 3'h0;
    end else if (pu_done) begin
      final_byte_bit_count <= FRAMING_STORED;
    end else if (tx_finish) begin
      final_byte_bit_count <= 3'h0;
    end else if (dp_wr && dp_addr == ADDR_FRAMING && state != ST_POWER_UP) begin
      final_byte_bit_count <= i_hwdata[2:0];
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags <= 2'b00;
    end else if (pu_restart) begin
      flags <= 2'b00;
    end else begin
      flags[FLAG_IDLE] <= (flags[FLAG_IDLE] & ~(dp_wr && dp_addr == ADDR_FLAGS
                          && state != ST_POWER_UP && i_hwdata[FLAG_IDLE]))
                          | pu_done | tx_finish;
      flags[FLAG_TX]   <= (flags[FLAG_TX] & ~(dp_wr && dp_addr == ADDR_FLAGS
                          && state != ST_POWER_UP && i_hwdata[FLAG_TX]))
                          | tx_finish;
    end
  end

  // ---------------------------------------------------------------
  // FIFO; idle abort never touches it
  // ---------------------------------------------------------------
  assign fifo_empty = fifo_count == 7'd0;
  assign fifo_full  = fifo_count == 7'(FIFO_DEPTH);
  assign push       = dp_wr && dp_addr == ADDR_FIFO_DATA && state != ST_POWER_UP && !fifo_full;
  assign pop        = start_load | cont_pop;

  always_ff @(posedge i_clk) begin
    if (push) begin
      fifo_mem[wptr] <= i_hwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wptr       <= 6'h00;
      rptr       <= 6'h00;
      fifo_count <= 7'h00;
    end else if (pu_restart) begin
      wptr       <= 6'h00;
      rptr       <= 6'h00;
      fifo_count <= 7'h00;
    end else begin
      if (push) begin
        wptr <= wptr + 6'h01;
      end
      if (pop) begin
        rptr <= rptr + 6'h01;
      end
      fifo_count <= fifo_count + 7'(push) - 7'(pop);
    end
  end

  // ---------------------------------------------------------------
  // bit period divider, restarted when a frame begins
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt <= 16'h0000;
    end else if (start_load || div_cnt == 16'(BIT_DIV - 1)) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign tick = div_cnt == 16'(BIT_DIV - 1);

  // ---------------------------------------------------------------
  // transmit framing
  // ---------------------------------------------------------------
  assign par_bit   = odd_parity_sel ? ~(^shreg) : ^shreg;
  assign slot_bit  = bit_idx[3] ? par_bit : shreg[bit_idx[2:0]];
  assign byte_last = parity_gen_en ? bit_idx == 4'd8 : bit_idx == 4'd7;
  assign part_last = final_byte_bit_count != 3'h0
                     && bit_idx == {1'b0, final_byte_bit_count - 3'h1};
  assign start_load = !fifo_empty && !pu_restart
                      && ((state == ST_IDLE && wr_cmd && i_hwdata[5:0] == CMD_TRANSMIT)
                          || (state == ST_TX_ARMED && !abort));
  // pops the next byte; the data state repeats this test to decide whether the stream goes on
  assign cont_pop  = tick && !abort && !pu_restart && state == ST_TX_DATA
                     && byte_last && !fifo_empty;
  assign tx_finish = tick && !abort && !pu_restart && state == ST_TX_END;

  always_comb begin
    next_crc = crc;
    if (check8_sel) begin
      next_crc[7:0] = {1'b0, crc[7:1]} ^ ((crc[0] ^ slot_bit) ? CHECK8_POLY : 8'h00);
    end else begin
      next_crc = {1'b0, crc[15:1]} ^ ((crc[0] ^ slot_bit) ? CHECK16_POLY : 16'h0000);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state       <= ST_POWER_UP;
      shreg       <= 8'h00;
      check_hi    <= 8'h00;
      check_left  <= 1'b0;
      bit_idx     <= 4'h0;
      crc         <= 16'h0000;
      o_tx_bit    <= 1'b0;
      o_tx_active <= 1'b0;
    end else if (pu_restart) begin
      state       <= ST_POWER_UP;
      o_tx_bit    <= 1'b0;
      o_tx_active <= 1'b0;
    end else if (abort) begin
      state       <= ST_IDLE;
      o_tx_bit    <= 1'b0;
      o_tx_active <= 1'b0;
    end else if (start_load) begin
      state   <= ST_TX_SOF;
      shreg   <= fifo_mem[rptr];
      bit_idx <= 4'h0;
      crc     <= check8_sel ? {8'h00, CHECK8_PRESET} : CHECK16_PRESET;
    end else begin
      case (state)
        ST_POWER_UP: begin
          if (pu_done) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (wr_cmd && i_hwdata[5:0] == CMD_TRANSMIT) begin
            state <= ST_TX_ARMED;
          end
        end
        ST_TX_ARMED: state <= ST_TX_ARMED;
        ST_TX_SOF: begin
          if (tick) begin
            o_tx_bit    <= 1'b1;
            o_tx_active <= 1'b1;
            state       <= ST_TX_DATA;
          end
        end
        ST_TX_DATA: begin
          if (tick) begin
            o_tx_bit <= slot_bit;
            bit_idx  <= bit_idx + 4'h1;
            if (!bit_idx[3]) begin
              crc <= next_crc;
            end
            if (part_last && fifo_empty) begin
              state <= ST_TX_EOF;
            end else if (byte_last && !fifo_empty) begin
              shreg   <= fifo_mem[rptr];
              bit_idx <= 4'h0;
            end else if (byte_last) begin
              bit_idx <= 4'h0;
              if (tx_check_append_en) begin
                state      <= ST_TX_CHECK;
                shreg      <= next_crc[7:0];
                check_hi   <= next_crc[15:8];
                check_left <= !check8_sel;
              end else begin
                state <= ST_TX_EOF;
              end
            end
          end
        end
        ST_TX_CHECK: begin
          if (tick) begin
            o_tx_bit <= slot_bit;
            bit_idx  <= bit_idx + 4'h1;
            if (byte_last) begin
              bit_idx <= 4'h0;
              if (check_left) begin
                shreg      <= check_hi;
                check_left <= 1'b0;
              end else begin
                state <= ST_TX_EOF;
              end
            end
          end
        end
        ST_TX_EOF: begin
          if (tick) begin
            o_tx_bit <= 1'b0;
            state    <= ST_TX_END;
          end
        end
        ST_TX_END: begin
          if (tick) begin
            o_tx_active <= 1'b0;
            state       <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n || pu_restart);

  abort_stop_a: assert property (abort |=> state == ST_IDLE && !o_tx_active)
    else $error("transmit did not stop after command replaced");
  power_up_lock_a: assert property (state == ST_POWER_UP && dp_wr |=> state == ST_POWER_UP
                                    || $past(pu_done))
    else $error("power-up left by a host write");
  power_up_end_a: assert property (pu_done |=> state == ST_IDLE && flags[FLAG_IDLE])
    else $error("power-up did not end in idle with flag");
  abort_flag_a: assert property (abort && !flags[FLAG_IDLE] |=> !flags[FLAG_IDLE])
    else $error("idle abort raised the idle flag");
  abort_fifo_a: assert property (abort && !push |=> fifo_count == $past(fifo_count))
    else $error("abort changed the FIFO level");
  tx_done_a: assert property (tx_finish |=> flags[FLAG_TX] && flags[FLAG_IDLE]
                              && final_byte_bit_count == 3'h0 && state == ST_IDLE)
    else $error("transmit end missed flags or count clear");
  armed_wait_a: assert property (state == ST_IDLE && wr_cmd && i_hwdata[5:0] == CMD_TRANSMIT
                                 && fifo_empty |=> state == ST_TX_ARMED [*2])
    else $error("empty transmit did not stay armed");
  empty_end_a: assert property (tick && state == ST_TX_DATA && byte_last && fifo_empty
                                && !abort |=> state != ST_TX_DATA)
    else $error("data phase continued with empty FIFO");
  parity_bit_a: assert property (tick && state == ST_TX_DATA && bit_idx == 4'd8 && !abort
                                 |=> o_tx_bit == (^$past(shreg) ^ $past(odd_parity_sel)))
    else $error("parity bit value wrong");
  sof_first_a: assert property (state == ST_TX_SOF && tick && !abort
                                |=> o_tx_active && o_tx_bit && state == ST_TX_DATA)
    else $error("frame did not open with start pattern");

endmodule

// File: reader_command_sequencer_tx_tb.sv
// Purpose: self-checking bench of the reader command sequencer
// Assumes: bit period shortened to four clocks
// Notes:   frames are sampled mid-bit, first bit lands in bit 0
module reader_command_sequencer_tx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rcs_pkg::*;
  localparam int          DIV  = 4;
  localparam logic [31:0] TX   = {26'h0, CMD_TRANSMIT};
  localparam logic [31:0] BUSY = 32'h1 << STAT_PWR_BUSY;
  localparam logic [39:0] ROWS [7] = '{
    {ADDR_STATUS, 32'h1 << STAT_FIFO_EMPTY}, {ADDR_COMMAND, 32'h0},
    {ADDR_FIFO_LEVEL, 32'h0}, {ADDR_FLAGS, 32'h1 << FLAG_IDLE},
    {ADDR_REDUNDANCY, {28'h0, RED_STORED}}, {ADDR_FRAMING, {29'h0, FRAMING_STORED}},
    {8'h1c, 32'h0}};
  logic        clk, reset_n, pin, hsel, hwrite, hready, hresp, tx_bit, tx_active;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          fail_count = 0;
  int          compares   = 0;

  rcs_host_model host (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
    .o_hwdata(hwdata));
  rcs_sequencer #(.BIT_DIV(DIV)) DUT (.i_clk(clk), .i_reset_n(reset_n),
    .i_reset_powerdown_pin(pin), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_tx_bit(tx_bit),
    .o_tx_active(tx_active));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'h0, a, 32'h0, q);
    check(n, q & m, e);
  endtask

  task automatic wait_tx(input logic v);
    int i;
    i = 0;
    while (tx_active !== v && i < 400) begin
      @(posedge clk);
      #1;
      i++;
    end
    check("tx_active", 32'(tx_active), 32'(v));
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] d);
    logic [15:0] c;
    c = CHECK16_PRESET ^ {8'h0, d};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ CHECK16_POLY : c >> 1;
    return c;
  endfunction

  // one frame, then the self-ended command's side effects
  task automatic frame_chk(input int n, input logic [31:0] e);
    logic [31:0] v;
    v = 32'h0;
    wait_tx(1'h1);
    repeat (DIV / 2) @(posedge clk);
    #1;
    for (int k = 0; k < n; k++) begin
      v[k] = tx_bit;
      repeat (DIV) @(posedge clk);
      #1;
    end
    check("frame", v, e);
    wait_tx(1'h0);
    repeat (2) @(posedge clk);
    rd("flags", ADDR_FLAGS, 32'h3, 32'h3);
    rd("command", ADDR_COMMAND, 32'h3f, 32'h0);
    rd("final count", ADDR_FRAMING, 32'h7, 32'h0);
    host.write(ADDR_FLAGS, 32'h3);
  endtask

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // hang guard: the whole sequence needs well under a thousand clocks
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  // ----
  // main sequence
  // ----
  initial begin
    logic ok;
    reset_n = 1'h0;
    pin     = 1'h1;
    repeat (16) @(posedge clk);
    #1;
    check("reset outs", {hrdata[27:0], hready, hresp, tx_bit, tx_active}, 32'h8);
    @(posedge clk);
    reset_n <= 1'h1;
    rd("cmd in power-up", ADDR_COMMAND, 32'hffffffff, 32'h0);
    rd("busy", ADDR_STATUS, BUSY, BUSY);
    host.wait_idle(ok);
    check("power-up end", 32'(ok), 32'h1);
    foreach (ROWS[i]) rd("register", ROWS[i][39:32], 32'hffffffff, ROWS[i][31:0]);
    host.write(ADDR_COMMAND, {26'h0, CMD_POWER_UP});
    rd("host power-up", ADDR_STATUS, BUSY, 32'h0);
    rd("ignored code", ADDR_COMMAND, 32'h3f, 32'h0);
    host.write(ADDR_FLAGS, 32'h3);
    host.setup(4'h1, 3'h0);
    host.push(8'ha5);
    host.write(ADDR_COMMAND, TX);
    frame_chk(11, {21'h0, 1'h0, ^8'ha5, 8'ha5, 1'h1});
    host.setup(4'h3, 3'h0);
    host.write(ADDR_COMMAND, TX);
    repeat (3 * DIV) @(posedge clk);
    rd("armed", ADDR_STATUS, 32'h7, {29'h0, PHASE_ARMED});
    check("armed line", 32'(tx_active), 32'h0);
    host.push(8'h03);
    frame_chk(11, {21'h0, 1'h0, ~^8'h03, 8'h03, 1'h1});
    host.setup(4'h4, 3'h0);
    host.push(8'h5a);
    host.write(ADDR_COMMAND, TX);
    frame_chk(26, {6'h0, 1'h0, crc16(8'h5a), 8'h5a, 1'h1});
    host.setup(4'h1, 3'h3);
    host.push(8'h5e);
    host.write(ADDR_COMMAND, TX);
    frame_chk(5, {27'h0, 1'h0, 3'h6, 1'h1});
    host.setup(4'h0, 3'h0);
    host.push(8'h3c);
    host.write(ADDR_COMMAND, TX);
    fork
      frame_chk(18, {14'h0, 1'h0, 8'hc3, 8'h3c, 1'h1});
      begin
        repeat (3 * DIV) @(posedge clk);
        host.push(8'hc3);
      end
    join
    host.setup(4'h1, 3'h0);
    for (int i = 0; i < 3; i++) host.push(8'h11);
    host.write(ADDR_COMMAND, TX);
    wait_tx(1'h1);
    repeat (2 * DIV) @(posedge clk);
    host.write(ADDR_COMMAND, {26'h0, CMD_IDLE});
    @(posedge clk);
    #1;
    check("stopped", {30'h0, tx_active, tx_bit}, 32'h0);
    rd("abort flags", ADDR_FLAGS, 32'h3, 32'h0);
    rd("kept bytes", ADDR_FIFO_LEVEL, 32'h7f, 32'h2);
    rd("abort phase", ADDR_STATUS, 32'h7, 32'h0);
    @(posedge clk);
    pin <= 1'h0;
    repeat (4) @(posedge clk);
    host.push(8'h55);
    host.write(ADDR_FRAMING, 32'h5);
    host.wait_idle(ok);
    check("pin power-up", 32'(ok), 32'h1);
    rd("emptied", ADDR_FIFO_LEVEL, 32'h7f, 32'h0);
    rd("locked write", ADDR_FRAMING, 32'h7, 32'h0);
    rd("reloaded", ADDR_REDUNDANCY, 32'hf, {28'h0, RED_STORED});
    rd("pin idle flag", ADDR_FLAGS, 32'h1, 32'h1);
    report_and_stop();
  end
endmodule
